// ---- stc_core.sv ----
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module stc_core #(
	parameter int unsigned TICK_CYCLES = stc_pkg::TICK_CYCLES_DEF
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       hsel_i,
	input  wire logic [31:0]                haddr_i,
	input  wire logic [1:0]                 htrans_i,
	input  wire logic                       hwrite_i,
	input  wire logic [2:0]                 hsize_i,
	input  wire logic [31:0]                hwdata_i,
	input  wire logic                       hready_i,
	output logic      [31:0]                hrdata_o,
	output logic                            hreadyout_o,
	output logic                            hresp_o,
	input  wire logic [5:0]                 din_i,
	input  wire logic                       start_cmd_i,
	input  wire logic                       stop_cmd_i,
	input  wire logic                       fault_i,
	output logic      [3:0]                 dout_o,
	output stc_pkg::stc_step_cmd_type       step_cmd_o,
	output logic      [2:0]                 step_idx_o,
	output logic                            seq_run_o
);
	logic                      wr_q;
	logic                      rd_pend_q;
	logic [6:0]                addr_q;
	logic [31:0]               hrdata_q;
	logic [31:0]               rd_val;
	logic [31:0]               src_q;
	logic [31:0]               dsel_q;
	logic [31:0]               osel_q;
	logic [15:0]               level_q [4];
	logic [31:0]               step_q [8];
	logic [15:0]               speed_q [8];
	logic [8:0]                sy1_q;
	logic [8:0]                sy2_q;
	logic [8:0]                sy3_q;
	logic [31:0]               div_q;
	logic                      tick;
	logic [15:0]               timer_q;
	logic                      trun_q;
	logic [15:0]               count_q;
	logic [3:0]                dout_q;
	stc_pkg::stc_state_type    state_q;
	logic [2:0]                idx_q;
	logic [15:0]               sec_q;
	logic                      seen_q;
	stc_pkg::stc_step_cmd_type cmd_q;
	logic                      take;
	logic                      li1, li2, li1_rise;
	logic                      tstart_rise, trst, cin_rise, crst;
	logic                      start_rise, stop_lvl, fault_lvl;
	logic                      en;
	logic [4:0]                act_src;
	logic [15:0]               code;
	logic [15:0]               dur;
	logic [3:0]                cond;
	logic [3:0]                act;
	logic                      time_done, logic_ok, adv;

	// any input whose function select equals the code
	function automatic logic fn_any(input logic [5:0] bits, input logic [29:0] sel,
		input logic [4:0] fcode);
		logic r;
		r = 1'b0;
		for (int k = 0; k < stc_pkg::NUM_DIN; k++) begin
			r = r | (bits[k] & (sel[k*stc_pkg::SEL_W +: stc_pkg::SEL_W] == fcode));
		end
		return r;
	endfunction : fn_any

	// bus slave: writes land in the data phase, reads take one wait state
	assign take        = hsel_i & hready_i & htrans_i[1];
	assign hreadyout_o = ~rd_pend_q;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = hrdata_q;
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			wr_q      <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 7'h00;
		end else begin
			wr_q      <= take & hwrite_i;
			rd_pend_q <= take & ~hwrite_i;
			if (take) begin
				addr_q <= haddr_i[6:0];
			end
		end
	end

	// read mux; wait state lets a write just before a read be seen
	always_comb begin
		rd_val = stc_pkg::RST_WORD;
		case (addr_q[6:5])
			stc_pkg::LEVEL_BASE[6:5]: begin
				if (!addr_q[4]) begin
					rd_val = {16'h0000, level_q[addr_q[3:2]]};
				end
			end
			stc_pkg::STEP_BASE[6:5]: rd_val = step_q[addr_q[4:2]];
			stc_pkg::SPEED_BASE[6:5]: rd_val = {16'h0000, speed_q[addr_q[4:2]]};
			default: begin
				case ({addr_q[4:2], 2'b00})
					stc_pkg::OFS_SRC[4:0]: rd_val = src_q;
					stc_pkg::OFS_DSEL[4:0]: rd_val = dsel_q;
					stc_pkg::OFS_OSEL[4:0]: rd_val = osel_q;
					stc_pkg::OFS_STATUS[4:0]:
						rd_val = {timer_q, 8'h00, dout_q, seq_run_o, idx_q};
					stc_pkg::OFS_COUNT[4:0]: rd_val = {16'h0000, count_q};
					default: rd_val = stc_pkg::RST_WORD;
				endcase
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			hrdata_q <= stc_pkg::RST_WORD;
		end else if (rd_pend_q) begin
			hrdata_q <= rd_val;
		end
	end

	// configuration words; per-step values held per index
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			src_q  <= stc_pkg::RST_WORD;
			dsel_q <= stc_pkg::RST_WORD;
			osel_q <= stc_pkg::RST_WORD;
			for (int k = 0; k < stc_pkg::NUM_OUT; k++) begin
				level_q[k] <= 16'h0000;
			end
			for (int k = 0; k < stc_pkg::NUM_STEPS; k++) begin
				step_q[k]  <= stc_pkg::RST_WORD;
				speed_q[k] <= 16'h0000;
			end
		end else if (wr_q) begin
			if (addr_q == stc_pkg::OFS_SRC) begin
				src_q <= hwdata_i & stc_pkg::SRC_MASK;
			end
			if (addr_q == stc_pkg::OFS_DSEL) begin
				dsel_q <= hwdata_i & stc_pkg::DSEL_MASK;
			end
			if (addr_q == stc_pkg::OFS_OSEL) begin
				osel_q <= hwdata_i & stc_pkg::OSEL_MASK;
			end
			if (addr_q[6:5] == stc_pkg::LEVEL_BASE[6:5] && !addr_q[4]) begin
				level_q[addr_q[3:2]] <= hwdata_i[15:0];
			end
			if (addr_q[6:5] == stc_pkg::STEP_BASE[6:5]) begin
				step_q[addr_q[4:2]] <= hwdata_i;
			end
			if (addr_q[6:5] == stc_pkg::SPEED_BASE[6:5]) begin
				speed_q[addr_q[4:2]] <= hwdata_i[15:0];
			end
		end
	end

	// pin synchronisers; third stage only holds last value for edges
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			sy1_q <= 9'h000;
			sy2_q <= 9'h000;
			sy3_q <= 9'h000;
		end else begin
			sy1_q <= {fault_i, stop_cmd_i, start_cmd_i, din_i};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	// input function decode
	always_comb begin
		li1 = fn_any(sy2_q[5:0], dsel_q[29:0], stc_pkg::FN_LOGIC_ONE);
		li2 = fn_any(sy2_q[5:0], dsel_q[29:0], stc_pkg::FN_LOGIC_TWO);
		li1_rise = li1 & ~fn_any(sy3_q[5:0], dsel_q[29:0], stc_pkg::FN_LOGIC_ONE);
		tstart_rise = fn_any(sy2_q[5:0], dsel_q[29:0], stc_pkg::FN_TIMER_START)
			& ~fn_any(sy3_q[5:0], dsel_q[29:0], stc_pkg::FN_TIMER_START);
		trst = fn_any(sy2_q[5:0], dsel_q[29:0], stc_pkg::FN_TIMER_RST);
		cin_rise = fn_any(sy2_q[5:0], dsel_q[29:0], stc_pkg::FN_COUNT_IN)
			& ~fn_any(sy3_q[5:0], dsel_q[29:0], stc_pkg::FN_COUNT_IN);
		crst = fn_any(sy2_q[5:0], dsel_q[29:0], stc_pkg::FN_COUNT_RST);
		start_rise = sy2_q[6] & ~sy3_q[6];
		stop_lvl   = sy2_q[7];
		fault_lvl  = sy2_q[8];
	end

	// one-second enable pulse
	assign tick = (div_q == 32'(TICK_CYCLES - 1));
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i || tick) begin
			div_q <= 32'h0000_0000;
		end else begin
			div_q <= div_q + 32'h0000_0001;
		end
	end

	// timer in whole seconds, saturating
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			timer_q <= 16'h0000;
			trun_q  <= 1'b0;
		end else if (trst) begin
			timer_q <= 16'h0000;
			trun_q  <= 1'b0;
		end else if (tstart_rise) begin
			timer_q <= 16'h0000;
			trun_q  <= 1'b1;
		end else if (trun_q && tick && timer_q != 16'hffff) begin
			timer_q <= timer_q + 16'h0001;
		end
	end

	// event counter; reset level wins over a count edge
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i || crst) begin
			count_q <= 16'h0000;
		end else if (cin_rise && count_q != 16'hffff) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// relay and opto outputs
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			dout_q <= 4'h0;
		end else begin
			for (int k = 0; k < stc_pkg::NUM_OUT; k++) begin
				case (osel_q[k*stc_pkg::OSEL_STRIDE +: stc_pkg::SEL_W])
					stc_pkg::OSEL_TIMER: dout_q[k] <= trun_q && timer_q < level_q[k];
					stc_pkg::OSEL_COUNTER: dout_q[k] <= count_q >= level_q[k];
					default: dout_q[k] <= 1'b0;
				endcase
			end
		end
	end

	// active source must carry the sequencer code
	always_comb begin
		case (src_q[stc_pkg::SRC_ACT_LSB +: 2])
			2'h0: act_src = src_q[4:0];
			2'h1: act_src = src_q[stc_pkg::SRC_FLD_STRIDE +: stc_pkg::SEL_W];
			2'h2: act_src = src_q[2*stc_pkg::SRC_FLD_STRIDE +: stc_pkg::SEL_W];
			default: act_src = 5'h1f;
		endcase
		en = (act_src == stc_pkg::SRC_STEP_SEQ);
	end

	// step transition decision
	always_comb begin
		code      = step_q[idx_q][15:0];
		dur       = step_q[idx_q][31:16];
		cond      = code[3:0];
		act       = code[15:12];
		time_done = sec_q >= dur;
		case (cond)
			stc_pkg::COND_TIME: logic_ok = time_done;
			stc_pkg::COND_LI1_EDGE: logic_ok = seen_q | li1_rise;
			stc_pkg::COND_BOTH_ON: logic_ok = li1 & li2;
			stc_pkg::COND_LI2_OFF: logic_ok = ~li2;
			default: logic_ok = 1'b0;
		endcase
		// nonzero second digit asks for minimum time before logic
		adv = (state_q == stc_pkg::ST_RUN) & logic_ok
			& ((code[7:4] == 4'h0) | time_done);
	end

	// sequencer state, step index and time in step
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i || stop_lvl || fault_lvl || !en) begin
			state_q <= stc_pkg::ST_IDLE;
			idx_q   <= 3'h0;
			sec_q   <= 16'h0000;
			seen_q  <= 1'b0;
		end else begin
			case (state_q)
				stc_pkg::ST_IDLE: begin
					if (start_rise) begin
						state_q <= stc_pkg::ST_RUN;
						idx_q   <= 3'h0;
						sec_q   <= 16'h0000;
						seen_q  <= 1'b0;
					end
				end
				stc_pkg::ST_RUN: begin
					if (adv) begin
						idx_q  <= idx_q + 3'h1;
						sec_q  <= 16'h0000;
						seen_q <= 1'b0;
					end else begin
						if (tick && sec_q != 16'hffff) begin
							sec_q <= sec_q + 16'h0001;
						end
						if (li1_rise) begin
							seen_q <= 1'b1;
						end
					end
				end
				default: state_q <= stc_pkg::ST_IDLE;
			endcase
		end
	end

	// step command: speed per step index, the rest from top digit; idle commands nothing
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i || state_q != stc_pkg::ST_RUN) begin
			cmd_q <= '{16'h0000, stc_pkg::DIR_NONE, 1'b0, 1'b0};
		end else begin
			cmd_q.speed    <= speed_q[idx_q];
			cmd_q.dir      <= 2'(act % 4'h3);
			cmd_q.ramp_two <= act >= stc_pkg::ACT_RAMP_TWO;
			cmd_q.out_on   <= 4'(act % 4'h6) >= 4'h3;
		end
	end

	assign dout_o     = dout_q;
	assign step_cmd_o = cmd_q;
	assign step_idx_o = idx_q;
	assign seq_run_o  = (state_q == stc_pkg::ST_RUN);

	AST_EN_GATE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!en |=> !seq_run_o) else $error("sequencer ran without step source");
	AST_START_ZERO: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(!seq_run_o && start_rise && en && !stop_lvl && !fault_lvl)
		|=> seq_run_o && idx_q == 3'h0) else $error("start did not begin at step zero");
	AST_WRAP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(adv && idx_q == 3'h7 && en && !stop_lvl && !fault_lvl) |=> idx_q == 3'h0)
		else $error("step seven did not wrap");
	AST_STOP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(stop_lvl || fault_lvl) |=> !seq_run_o && idx_q == 3'h0)
		else $error("stop or fault left sequence running");
	AST_BOTH_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(seq_run_o && cond == stc_pkg::COND_BOTH_ON && !(li1 && li2))
		|=> $stable(idx_q)) else $error("level step advanced without both inputs");
	AST_TSTART: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(tstart_rise && !trst) |=> timer_q == 16'h0000 && trun_q ##1 trun_q)
		else $error("timer start did not clear and run");
	AST_TRST: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		trst |=> timer_q == 16'h0000 && !trun_q) else $error("timer reset ignored");
	AST_CRST: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		crst |=> count_q == 16'h0000) else $error("counter reset ignored");
	AST_CINC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cin_rise && !crst && count_q != 16'hffff) |=> count_q == $past(count_q) + 16'h0001)
		else $error("count edge not counted");
	AST_TOUT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(osel_q[4:0] == stc_pkg::OSEL_TIMER && $stable(osel_q) && trun_q
		&& timer_q >= level_q[0] && $stable(level_q[0])) |=> !dout_o[0])
		else $error("timer output on after time reached");
endmodule : stc_core

// ---- stc_pkg.sv ----
// Function
// - sequencer runs only while the active speed source holds the step code
// - each of eight steps keeps logic code, preset speed and duration
// - a sequence starts only on a valid start command
// - timed operation begins at step zero, advances when step time expires
// - step seven is followed by step zero
// - sequence repeats until stop command or fault
// - each step may command forward or reverse direction
// - input function 24 is logic input one, 25 is logic input two
// - edge condition advances on off-to-on of logic input one
// - level condition advances only while both logic inputs are on
// - a condition fires when logic input two returns off
// - step time and logic condition combine as minimum time then logic
// - input function 19 starts the timer, 21 resets it
// - output select 25 changes state when timer reaches level seconds
// - timer start input clears and restarts the timer
// - timer output is on while timing and off once time is reached
// - input function 20 is count input, 22 resets the counter
// - counter reset input returns counter to zero
// - timer reset input clears the timer
// - top digit of step code selects ramp set, step output, direction
package stc_pkg;
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned SEC_NS          = 1_000_000_000;
	localparam int unsigned TICK_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
	localparam int          NUM_STEPS       = 8;
	localparam int          NUM_DIN         = 6;
	localparam int          NUM_OUT         = 4;
	localparam int          SEL_W           = 5;
	localparam int          VAL_W           = 16;
	// function and select codes
	localparam logic [4:0]  SRC_STEP_SEQ    = 5'h0d;
	localparam logic [4:0]  FN_TIMER_START  = 5'h13;
	localparam logic [4:0]  FN_COUNT_IN     = 5'h14;
	localparam logic [4:0]  FN_TIMER_RST    = 5'h15;
	localparam logic [4:0]  FN_COUNT_RST    = 5'h16;
	localparam logic [4:0]  FN_LOGIC_ONE    = 5'h18;
	localparam logic [4:0]  FN_LOGIC_TWO    = 5'h19;
	localparam logic [4:0]  OSEL_TIMER      = 5'h19;
	localparam logic [4:0]  OSEL_COUNTER    = 5'h1a;
	// step transition codes in the lowest digit, top-digit action code, direction values
	localparam logic [3:0]  COND_TIME       = 4'h0;
	localparam logic [3:0]  COND_LI1_EDGE   = 4'h1;
	localparam logic [3:0]  COND_BOTH_ON    = 4'h2;
	localparam logic [3:0]  COND_LI2_OFF    = 4'h3;
	localparam logic [3:0]  ACT_RAMP_TWO    = 4'h6;
	localparam logic [1:0]  DIR_FWD         = 2'h0;
	localparam logic [1:0]  DIR_REV         = 2'h1;
	localparam logic [1:0]  DIR_NONE        = 2'h2;
	// register byte offsets and masks
	localparam logic [6:0]  OFS_SRC         = 7'h00;
	localparam logic [6:0]  OFS_DSEL        = 7'h04;
	localparam logic [6:0]  OFS_OSEL        = 7'h08;
	localparam logic [6:0]  OFS_STATUS      = 7'h0c;
	localparam logic [6:0]  OFS_COUNT       = 7'h10;
	localparam logic [6:0]  LEVEL_BASE      = 7'h20;
	localparam logic [6:0]  STEP_BASE       = 7'h40;
	localparam logic [6:0]  SPEED_BASE      = 7'h60;
	localparam logic [31:0] SRC_MASK        = 32'h031f_1f1f;
	localparam logic [31:0] DSEL_MASK       = 32'h3fff_ffff;
	localparam logic [31:0] OSEL_MASK       = 32'h1f1f_1f1f;
	localparam logic [31:0] RST_WORD        = 32'h0000_0000;
	localparam int          SRC_ACT_LSB     = 24;
	localparam int          SRC_FLD_STRIDE  = 8;
	localparam int          OSEL_STRIDE     = 8;
	typedef enum logic {ST_IDLE, ST_RUN} stc_state_type;
	typedef struct packed {
		logic [15:0] speed;
		logic [1:0]  dir;
		logic        ramp_two;
		logic        out_on;
	} stc_step_cmd_type;
endpackage : stc_pkg

// ---- stc_machine.sv ----
`timescale 1ns/1ns
// machine side: terminal inputs and run commands, all moved just after a rising edge
module stc_machine (
	input  wire logic       ref_clk_i,
	input  wire logic [3:0] dout_i,
	output logic      [5:0] din_o,
	output logic            start_cmd_o,
	output logic            stop_cmd_o,
	output logic            fault_o
);
	initial begin
		din_o = 6'h00;
		start_cmd_o = 1'b0;
		stop_cmd_o = 1'b0;
		fault_o = 1'b0;
	end
	// whole input vector at once, so combined conditions appear together
	task automatic set_din(input logic [5:0] v);
		@(posedge ref_clk_i);
		din_o <= v;
	endtask : set_din
	// pulse held long enough to cross the two-stage input sync
	task automatic pulse_din(input int k);
		@(posedge ref_clk_i);
		din_o[k] <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		din_o[k] <= 1'b0;
	endtask : pulse_din
	task automatic pulse_start;
		@(posedge ref_clk_i);
		start_cmd_o <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		start_cmd_o <= 1'b0;
	endtask : pulse_start
	task automatic set_halt(input logic stop, input logic flt);
		@(posedge ref_clk_i);
		stop_cmd_o <= stop;
		fault_o <= flt;
	endtask : set_halt
endmodule : stc_machine

// ---- test_step_sequencer_timer_counter.sv ----
`timescale 1ns/1ns
module test_step_sequencer_timer_counter;
	logic                      ref_clk_i = 1'b0;
	logic                      reset_n_i = 1'b0;
	logic [31:0]               haddr_i = 32'h0000_0000;
	logic [1:0]                htrans_i = 2'h0;
	logic                      hwrite_i = 1'b0;
	logic [31:0]               hwdata_i = 32'h0000_0000;
	logic [31:0]               hrdata_o;
	logic                      hreadyout_o;
	logic [5:0]                din_i;
	logic                      start_cmd_i;
	logic                      stop_cmd_i;
	logic                      fault_i;
	logic [3:0]                dout_o;
	stc_pkg::stc_step_cmd_type step_cmd_o;
	logic [2:0]                step_idx_o;
	logic                      seq_run_o;
	int                        n_mismatch = 0;
	int                        n_checks = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	// short tick keeps seconds at ten cycles
	stc_core #(.TICK_CYCLES(10)) u_stc_core (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .hsel_i(1'b1), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(),
		.din_i(din_i), .start_cmd_i(start_cmd_i), .stop_cmd_i(stop_cmd_i), .fault_i(fault_i),
		.dout_o(dout_o), .step_cmd_o(step_cmd_o), .step_idx_o(step_idx_o), .seq_run_o(seq_run_o));
	stc_machine u_stc_machine (
		.ref_clk_i(ref_clk_i), .dout_i(dout_o), .din_o(din_i), .start_cmd_o(start_cmd_i),
		.stop_cmd_o(stop_cmd_i), .fault_o(fault_i));
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : cyc
	// bounded wait for hready sampled high at a rising edge
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 16);
	endtask : wait_rdy
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		haddr_i <= {25'h0, a};
		htrans_i <= 2'h2;
		hwrite_i <= 1'b1;
		wait_rdy();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wait_rdy();
	endtask : wr
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp, input string what);
		@(posedge ref_clk_i);
		haddr_i <= {25'h0, a};
		htrans_i <= 2'h2;
		hwrite_i <= 1'b0;
		wait_rdy();
		htrans_i <= 2'h0;
		wait_rdy();
		chk(what, exp, hrdata_o);
	endtask : rd_chk
	task automatic wait_idx(input logic [2:0] v);
		int n;
		n = 0;
		while (step_idx_o !== v && n < 40) begin
			@(posedge ref_clk_i);
			n++;
		end
		chk("step index", {29'h0, v}, {29'h0, step_idx_o});
	endtask : wait_idx
	// a hang counts as a mismatch and ends through the same closing task
	initial begin
		cyc(20000);
		n_mismatch++;
		results();
	end
	initial begin
		logic [5:0] pre;
		cyc(16);
		reset_n_i <= 1'b1;
		chk("idle command", {13'h0, 16'h0000, stc_pkg::DIR_NONE, 2'h0}, step_cmd_o);
		rd_chk(stc_pkg::OFS_STATUS, 32'h0000_0000, "status reset");
		wr(stc_pkg::OFS_SRC, 32'hffff_ffff);
		rd_chk(stc_pkg::OFS_SRC, stc_pkg::SRC_MASK, "source fields");
		wr(7'h14, 32'hffff_ffff);
		rd_chk(7'h14, 32'h0000_0000, "unmapped");
		// inputs 0..5: count, count reset, timer start, timer reset, logic one, logic two
		wr(stc_pkg::OFS_DSEL, {2'h0, stc_pkg::FN_LOGIC_TWO, stc_pkg::FN_LOGIC_ONE,
			stc_pkg::FN_TIMER_RST, stc_pkg::FN_TIMER_START, stc_pkg::FN_COUNT_RST,
			stc_pkg::FN_COUNT_IN});
		wr(stc_pkg::OFS_OSEL, {19'h0, stc_pkg::OSEL_TIMER, 3'h0, stc_pkg::OSEL_COUNTER});
		wr(stc_pkg::LEVEL_BASE, 32'h0000_0003);
		wr(stc_pkg::LEVEL_BASE + 7'h04, 32'h0000_0002);
		u_stc_machine.pulse_din(0);
		u_stc_machine.pulse_din(0);
		cyc(6);
		chk("outputs below count", 32'h0000_0000, {28'h0, dout_o});
		u_stc_machine.pulse_din(0);
		cyc(6);
		rd_chk(stc_pkg::OFS_COUNT, 32'h0000_0003, "count");
		chk("outputs at count", 32'h0000_0001, {28'h0, dout_o});
		u_stc_machine.pulse_din(1);
		cyc(6);
		rd_chk(stc_pkg::OFS_COUNT, 32'h0000_0000, "count cleared");
		chk("outputs after clear", 32'h0000_0000, {28'h0, dout_o});
		$display("counter test done");
		u_stc_machine.pulse_din(2);
		cyc(6);
		chk("timer running", 32'h0000_0002, {28'h0, dout_o});
		cyc(40);
		chk("timer reached", 32'h0000_0000, {28'h0, dout_o});
		u_stc_machine.pulse_din(2);
		cyc(6);
		chk("timer restarted", 32'h0000_0002, {28'h0, dout_o});
		u_stc_machine.pulse_din(3);
		cyc(6);
		rd_chk(stc_pkg::OFS_STATUS, 32'h0000_0000, "timer cleared");
		$display("timer test done");
		// step code active in source one, but source two is the active reference
		wr(stc_pkg::OFS_SRC, 32'h0100_000d);
		u_stc_machine.pulse_start();
		cyc(8);
		chk("run refused", 32'h0000_0000, {31'h0, seq_run_o});
		wr(stc_pkg::OFS_SRC, 32'h0100_0d00);
		wr(stc_pkg::SPEED_BASE, 32'h0000_1234);
		wr(stc_pkg::STEP_BASE + 7'h04, 32'h0002_0000);
		// conditions 1..3 in step zero, ramp one, output on, reverse
		for (int c = 1; c <= 3; c++) begin
			pre = (c == 3) ? 6'h20 : 6'h00;
			u_stc_machine.set_din(pre);
			wr(stc_pkg::STEP_BASE, {16'h0000, 12'h400, c[3:0]});
			u_stc_machine.pulse_start();
			cyc(20);
			chk("run flag", 32'h0000_0001, {31'h0, seq_run_o});
			chk("step command", {13'h0, 16'h1234, stc_pkg::DIR_REV, 2'h1}, step_cmd_o);
			rd_chk(stc_pkg::OFS_STATUS, 32'h0000_0008, "waiting in step zero");
			case (c)
				1: u_stc_machine.pulse_din(4);
				2: begin
					u_stc_machine.set_din(6'h30);
					cyc(3);
					u_stc_machine.set_din(6'h00);
				end
				default: u_stc_machine.set_din(6'h00);
			endcase
			wait_idx(3'h1);
			if (c == 3) u_stc_machine.set_din(6'h20);
			wait_idx(3'h0);
			cyc(10);
			chk("held at step zero", 32'h0000_0001, {31'h0, seq_run_o});
			u_stc_machine.set_halt(c != 2, c == 2);
			cyc(6);
			chk("halted", 32'h0000_0000, {28'h0, step_idx_o, seq_run_o});
			u_stc_machine.set_halt(1'b0, 1'b0);
			$display("sequence condition %0d test done", c);
		end
		results();
	end
endmodule : test_step_sequencer_timer_counter
